// ---- rtl/serial_lane_sample_packer.sv ----
/*
 Transport-layer packer: one input frame of sample slots becomes one lane
 frame on lane groups A and B, laid out by the link format selector.
 Assumes inputs synchronous to core_clk, the receiver honours lane_valid
 and lane_ready, and it unpacks by the same selector.
*/
// Contract
// - 12-lane single: even samples A, odd B
// - 12-lane dual: channels packed contiguously, MSB first
// - Sixteen-bit lanes, three-lane 12-bit packing cycle
// - 6-lane single: even A0-A2, odd B0-B2
// - 6-lane dual: four samples per group
// - 8-bit: one sample per lane frame
// - 4-lane decimate-by-4: I on A, Q on B
// - 8-lane decimate-by-4: four words, own flags
// - 2-lane decimate-by-8: one I, one Q
// - 4-lane decimate-by-8: two words per group
// - 16-lane decimate-by-4: word pairs share flags
// - 8-lane decimate-by-8: flag index equals word
// - 16-lane decimate-by-8: eight words, own flags
`timescale 1ns/1ps
module serial_lane_sample_packer
   import lane_packer_pkg::*;
#(
   parameter int SLOT_W = `LANE_W,
   parameter int SLOTS = `SLOTS,
   parameter int LANES = `LANES,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [`LFS_W-1:0] link_format_selector,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [SLOTS*SLOT_W-1:0] sample_data,
   input wire logic [`FLAGS-1:0] inphase_overrange_flag,
   input wire logic [`FLAGS-1:0] quadrature_overrange_flag,
   output logic lane_valid,
   input wire logic lane_ready,
   output logic [LANES*`LANE_W-1:0] lane_a_data,
   output logic [LANES*`LANE_W-1:0] lane_b_data,
   output logic [LANES-1:0] lane_a_enable,
   output logic [LANES-1:0] lane_b_enable,
   output logic [1:0] lane_octets,
   output logic format_error
);
   localparam int DATA_W = SLOTS * SLOT_W;
   localparam int FIFO_W = DATA_W + 2 * `FLAGS + `LFS_W;

   // The slot map below is fixed to sixteen 16-bit slots and eight lanes
   if (SLOT_W != `LANE_W || SLOTS != `SLOTS || LANES != `LANES || FIFO_DEPTH < 2)
   begin : g_bad_param
      $error("serial_lane_sample_packer needs 16 slots of 16 bits and 8 lanes");
   end

   // Reset release through two flip-flops
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Frame FIFO: selector travels with its frame so a change lands on a boundary
   wire logic [FIFO_W-1:0] fifo_in;
   wire logic [FIFO_W-1:0] fifo_out;
   wire logic fifo_out_valid;
   wire logic fifo_out_ready;
   wire logic fifo_in_ready;
   assign fifo_in = {link_format_selector, quadrature_overrange_flag,
                     inphase_overrange_flag, sample_data};
   assign sample_ready = fifo_in_ready;

   frame_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(core_clk),
      .rst_n(rst_sync_reg),
      .in_valid(sample_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   // Fields of the frame at the FIFO head
   wire logic [DATA_W-1:0] head_data;
   wire logic [`FLAGS-1:0] head_iflag;
   wire logic [`FLAGS-1:0] head_qflag;
   wire logic [`LFS_W-1:0] head_sel;
   assign head_data = fifo_out[DATA_W-1:0];
   assign head_iflag = fifo_out[DATA_W +: `FLAGS];
   assign head_qflag = fifo_out[DATA_W + `FLAGS +: `FLAGS];
   assign head_sel = fifo_out[DATA_W + 2 * `FLAGS +: `LFS_W];

   // Selector decode into a packing layout
   format_t fmt;
   always_comb
   begin
      case (head_sel)
         `LFS_S12_12L_A, `LFS_S12_12L_B: fmt = FMT_S12_12L;
         `LFS_D12_12L_A, `LFS_D12_12L_B: fmt = FMT_D12_12L;
         `LFS_S12_6L: fmt = FMT_S12_6L;
         `LFS_D12_6L: fmt = FMT_D12_6L;
         `LFS_S8B_4L: fmt = FMT_S8B_4L;
         `LFS_S4_4L_A, `LFS_S4_4L_B: fmt = FMT_S4_4L;
         `LFS_S4_8L_A, `LFS_S4_8L_B: fmt = FMT_S4_8L;
         `LFS_S4_16L_A, `LFS_S4_16L_B: fmt = FMT_S4_16L;
         `LFS_S8_2L_A, `LFS_S8_2L_B, `LFS_S8_2L_C,
         `LFS_S8_2L_D, `LFS_S8_2L_E, `LFS_S8_2L_F: fmt = FMT_S8_2L;
         `LFS_S8_4L_A, `LFS_S8_4L_B, `LFS_S8_4L_C,
         `LFS_S8_4L_D, `LFS_S8_4L_E: fmt = FMT_S8_4L;
         `LFS_S8_8L_A, `LFS_S8_8L_B, `LFS_S8_8L_C: fmt = FMT_S8_8L;
         `LFS_S8_16L: fmt = FMT_S8_16L;
         default: fmt = FMT_NONE;
      endcase
   end

   // Layout class of the decoded format
   wire logic is_12bit;
   wire logic is_dual12;
   wire logic is_8bit;
   wire logic is_iq;
   wire logic pair_flags;
   assign is_12bit = (fmt == FMT_S12_12L) || (fmt == FMT_D12_12L) ||
                     (fmt == FMT_S12_6L) || (fmt == FMT_D12_6L);
   assign is_dual12 = (fmt == FMT_D12_12L) || (fmt == FMT_D12_6L);
   assign is_8bit = (fmt == FMT_S8B_4L);
   assign is_iq = (fmt == FMT_S4_4L) || (fmt == FMT_S4_8L) || (fmt == FMT_S4_16L) ||
                  (fmt == FMT_S8_2L) || (fmt == FMT_S8_4L) || (fmt == FMT_S8_8L) ||
                  (fmt == FMT_S8_16L);
   assign pair_flags = (fmt == FMT_S4_16L);

   // Lanes in use per group
   logic [`LANE_CNT_W-1:0] lane_cnt;
   always_comb
   begin
      case (fmt)
         FMT_S12_12L, FMT_D12_12L: lane_cnt = `LANE_CNT_6;
         FMT_S12_6L, FMT_D12_6L: lane_cnt = `LANE_CNT_3;
         FMT_S8B_4L, FMT_S4_4L, FMT_S8_4L: lane_cnt = `LANE_CNT_2;
         FMT_S4_8L, FMT_S8_8L: lane_cnt = `LANE_CNT_4;
         FMT_S4_16L, FMT_S8_16L: lane_cnt = `LANE_CNT_8;
         FMT_S8_2L: lane_cnt = `LANE_CNT_1;
         default: lane_cnt = `LANE_CNT_0;
      endcase
   end

   // Slot view of the head frame
   wire logic [SLOT_W-1:0] slot [0:SLOTS-1];
   genvar gs;
   for (gs = 0; gs < SLOTS; gs++)
   begin : g_slot
      assign slot[gs] = head_data[gs*SLOT_W +: SLOT_W];
   end

   // 12-bit samples chosen for each group, in transmit order
   wire logic [`SMP12_W-1:0] grp_a12 [0:7];
   wire logic [`SMP12_W-1:0] grp_b12 [0:7];
   wire logic [`PACK12_W-1:0] pack_a;
   wire logic [`PACK12_W-1:0] pack_b;
   genvar gk;
   for (gk = 0; gk < 8; gk++)
   begin : g_pick12
      // Single channel interleaves even and odd samples over the groups
      assign grp_a12[gk] = is_dual12 ? slot[gk][`SMP12_W-1:0]
                                     : slot[2*gk][`SMP12_W-1:0];
      assign grp_b12[gk] = is_dual12 ? slot[8+gk][`SMP12_W-1:0]
                                     : slot[2*gk+1][`SMP12_W-1:0];
      // Contiguous MSB-first bit stream per group
      assign pack_a[`PACK12_W-1-`SMP12_W*gk -: `SMP12_W] = grp_a12[gk];
      assign pack_b[`PACK12_W-1-`SMP12_W*gk -: `SMP12_W] = grp_b12[gk];
   end

   // Lane words for each layout class
   logic [`LANE_W-1:0] lane_a_next [0:LANES-1];
   logic [`LANE_W-1:0] lane_b_next [0:LANES-1];
   logic [LANES-1:0] en_next;
   genvar gn;
   for (gn = 0; gn < LANES; gn++)
   begin : g_lane
      wire logic [`LANE_W-1:0] a12;
      wire logic [`LANE_W-1:0] b12;
      wire logic [`LANE_W-1:0] a8;
      wire logic [`LANE_W-1:0] b8;
      wire logic [`LANE_W-1:0] aiq;
      wire logic [`LANE_W-1:0] biq;
      wire logic [2:0] flag_idx;
      wire logic lane_on;

      // Three lanes carry four 12-bit samples; lanes past the sixth stay idle
      if (gn < 6)
      begin : g_p12
         assign a12 = pack_a[`PACK12_W-1-`LANE_W*gn -: `LANE_W];
         assign b12 = pack_b[`PACK12_W-1-`LANE_W*gn -: `LANE_W];
      end
      else
      begin : g_n12
         assign a12 = '0;
         assign b12 = '0;
      end

      // One octet per lane frame, sent in the first octet
      if (gn < 2)
      begin : g_p8
         assign a8 = {slot[2*gn][`SMP8_W-1:0], 8'h00};
         assign b8 = {slot[2*gn+1][`SMP8_W-1:0], 8'h00};
      end
      else
      begin : g_n8
         assign a8 = '0;
         assign b8 = '0;
      end

      // Complex word over its flag; pairs share a flag in one layout
      assign flag_idx = pair_flags ? 3'(gn / 2) : 3'(gn);
      assign aiq = {slot[gn][`IQ_W-1:0], head_iflag[flag_idx]};
      assign biq = {slot[8+gn][`IQ_W-1:0], head_qflag[flag_idx]};

      // Lanes beyond the format's count send zero
      assign lane_on = (`LANE_CNT_W'(gn) < lane_cnt);
      assign en_next[gn] = lane_on;
      always_comb
      begin
         lane_a_next[gn] = '0;
         lane_b_next[gn] = '0;
         if (lane_on && is_12bit)
         begin
            lane_a_next[gn] = a12;
            lane_b_next[gn] = b12;
         end
         else if (lane_on && is_8bit)
         begin
            lane_a_next[gn] = a8;
            lane_b_next[gn] = b8;
         end
         else if (lane_on && is_iq)
         begin
            lane_a_next[gn] = aiq;
            lane_b_next[gn] = biq;
         end
      end
   end

   // Output stage takes a frame when empty or when the receiver accepts
   wire logic load_frame;
   assign load_frame = fifo_out_valid && (!lane_valid || lane_ready);
   assign fifo_out_ready = load_frame;

   // Flattened next lane words
   wire logic [LANES*`LANE_W-1:0] lane_a_flat;
   wire logic [LANES*`LANE_W-1:0] lane_b_flat;
   for (gn = 0; gn < LANES; gn++)
   begin : g_flat
      assign lane_a_flat[gn*`LANE_W +: `LANE_W] = lane_a_next[gn];
      assign lane_b_flat[gn*`LANE_W +: `LANE_W] = lane_b_next[gn];
   end

   // Octets per lane frame and the error mark
   wire logic [1:0] octets_next;
   wire logic fmt_err_next;
   assign octets_next = is_8bit ? `OCTETS_1 : `OCTETS_2;
   assign fmt_err_next = (fmt == FMT_NONE);

   // Valid handshake of the lane frame
   always_ff @(posedge core_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         lane_valid <= 1'b0;
      end
      else if (load_frame)
      begin
         lane_valid <= 1'b1;
      end
      else if (lane_ready)
      begin
         lane_valid <= 1'b0;
      end
   end

   // Lane frame registers, loaded together with its layout marks
   always_ff @(posedge core_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         lane_a_data <= '0;
         lane_b_data <= '0;
         lane_a_enable <= '0;
         lane_b_enable <= '0;
         lane_octets <= `OCTETS_RST;
         format_error <= 1'b0;
      end
      else if (load_frame)
      begin
         lane_a_data <= lane_a_flat;
         lane_b_data <= lane_b_flat;
         lane_a_enable <= en_next;
         lane_b_enable <= en_next;
         lane_octets <= octets_next;
         format_error <= fmt_err_next;
      end
   end

   // The far end rebuilds sample order from the same selector value
endmodule : serial_lane_sample_packer

// ---- rtl/lane_packer_params.svh ----
/*
 Constants of the serial lane sample packer: link format selector codes,
 sample and lane word layout, lane counts and reset values.
 Assumes it is included by bare name from the package and the testbench modules.
*/
`ifndef LANE_PACKER_PARAMS_SVH
`define LANE_PACKER_PARAMS_SVH

// Width of the link format selector
`define LFS_W 7

// Link format selector codes served by the packer
`define LFS_S12_12L_A 7'h13
`define LFS_S12_12L_B 7'h2a
`define LFS_D12_12L_A 7'h14
`define LFS_D12_12L_B 7'h2b
`define LFS_S4_4L_A 7'h15
`define LFS_S4_4L_B 7'h24
`define LFS_S4_8L_A 7'h16
`define LFS_S4_8L_B 7'h2e
`define LFS_S8_2L_A 7'h17
`define LFS_S8_2L_B 7'h26
`define LFS_S8_2L_C 7'h3d
`define LFS_S8_2L_D 7'h40
`define LFS_S8_2L_E 7'h45
`define LFS_S8_2L_F 7'h47
`define LFS_S8_4L_A 7'h18
`define LFS_S8_4L_B 7'h30
`define LFS_S8_4L_C 7'h3e
`define LFS_S8_4L_D 7'h41
`define LFS_S8_4L_E 7'h46
`define LFS_S4_16L_A 7'h19
`define LFS_S4_16L_B 7'h34
`define LFS_S8_8L_A 7'h1a
`define LFS_S8_8L_B 7'h36
`define LFS_S8_8L_C 7'h3f
`define LFS_S8_16L 7'h1b
`define LFS_S12_6L 7'h20
`define LFS_D12_6L 7'h21
`define LFS_S8B_4L 7'h22

// Sample and lane word layout
`define SMP12_W 12
`define SMP8_W 8
`define IQ_W 15
`define LANE_W 16
`define SLOTS 16
`define LANES 8
`define FLAGS 8
`define PACK12_W 96
`define FIFO_DEPTH 16

// Lanes in use per group for each lane count
`define LANE_CNT_W 4
`define LANE_CNT_1 4'h1
`define LANE_CNT_2 4'h2
`define LANE_CNT_3 4'h3
`define LANE_CNT_4 4'h4
`define LANE_CNT_6 4'h6
`define LANE_CNT_8 4'h8
`define LANE_CNT_0 4'h0

// Octets per lane frame
`define OCTETS_1 2'h1
`define OCTETS_2 2'h2
`define OCTETS_RST 2'h2

`endif

// ---- rtl/lane_packer_pkg.sv ----
/*
 Types of the serial lane sample packer.
 Assumes the constants header is on the include path.
*/
package lane_packer_pkg;
`include "lane_packer_params.svh"

   // Packing layout chosen by the link format selector
   typedef enum {
      FMT_NONE,
      FMT_S12_12L,
      FMT_D12_12L,
      FMT_S12_6L,
      FMT_D12_6L,
      FMT_S8B_4L,
      FMT_S4_4L,
      FMT_S4_8L,
      FMT_S4_16L,
      FMT_S8_2L,
      FMT_S8_4L,
      FMT_S8_8L,
      FMT_S8_16L
   } format_t;

endpackage : lane_packer_pkg

// ---- rtl/frame_fifo.sv ----
/*
 Synchronous FIFO with valid and ready on both sides.
 Assumes one clock and an already synchronised active-low reset.
*/
`timescale 1ns/1ps
module frame_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Depth must be a power of two for wrapping pointers
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin : g_bad_param
      $error("frame_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic not_full_reg;
   logic not_empty_reg;
   wire logic wr_en;
   wire logic rd_en;

   // Transfers on each side
   assign wr_en = in_valid && not_full_reg;
   assign rd_en = out_ready && not_empty_reg;
   assign count_next = count_reg + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
   assign in_ready = not_full_reg;
   assign out_valid = not_empty_reg;
   assign out_data = mem[rd_ptr_reg];

   // Storage array, no reset needed
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and level flags
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         not_full_reg <= 1'b1;
         not_empty_reg <= 1'b0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_reg + AW'(wr_en);
         rd_ptr_reg <= rd_ptr_reg + AW'(rd_en);
         count_reg <= count_next;
         not_full_reg <= (count_next != (AW + 1)'(DEPTH));
         not_empty_reg <= (count_next != '0);
      end
   end
endmodule : frame_fifo

// ---- testbench/lane_packer_properties.sv ----
/*
 Port checker of the serial lane sample packer.
 Assumes it is bound onto every packer instance with one clock domain.
*/
`timescale 1ns/1ps
`include "lane_packer_params.svh"
module lane_packer_properties
   import lane_packer_pkg::*;
#(
   parameter int LANES = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic lane_valid,
   input wire logic lane_ready,
   input wire logic [LANES*`LANE_W-1:0] lane_a_data,
   input wire logic [LANES*`LANE_W-1:0] lane_b_data,
   input wire logic [LANES-1:0] lane_a_enable,
   input wire logic [LANES-1:0] lane_b_enable,
   input wire logic [1:0] lane_octets,
   input wire logic format_error
);
   logic [LANES*`LANE_W-1:0] used_mask;

   // Lane enables spread to lane-wide masks
   always_comb
   begin
      for (int i = 0; i < LANES; i++)
         used_mask[i*`LANE_W +: `LANE_W] = {`LANE_W{lane_a_enable[i]}};
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Input frame accepted, and output frame waiting on the receiver
   sequence frame_taken;
      sample_valid && sample_ready;
   endsequence
   sequence frame_held;
      lane_valid && !lane_ready;
   endsequence

   frame_answer_a: assert property (frame_taken ##0 !lane_valid |-> ##[1:2] lane_valid)
      else $error("accepted frame never presented");
   held_frame_a: assert property (frame_held |=> lane_valid && $stable(lane_a_data)
      && $stable(lane_b_data) && $stable(lane_a_enable) && $stable(format_error))
      else $error("waiting lane frame changed");
   group_enables_a: assert property (lane_valid |-> lane_a_enable == lane_b_enable)
      else $error("lane groups differ in width");
   lane_count_a: assert property (lane_valid && !format_error |->
      lane_a_enable inside {8'h01, 8'h03, 8'h07, 8'h0f, 8'h3f, 8'hff})
      else $error("illegal lane count");
   unused_zero_a: assert property (lane_valid |-> ((lane_a_data | lane_b_data) & ~used_mask) == '0)
      else $error("unused lane not zero");
   error_blank_a: assert property (lane_valid && format_error |-> lane_a_enable == '0
      && lane_a_data == '0 && lane_b_data == '0)
      else $error("unsupported frame not blank");
   narrow_octet_a: assert property (lane_valid && lane_octets == `OCTETS_1 |->
      lane_a_enable == 8'h03 && lane_a_data[7:0] == 8'h00 && lane_b_data[23:16] == 8'h00)
      else $error("narrow frame layout wrong");
   wide_octets_a: assert property (lane_valid && !format_error && lane_a_enable inside
      {8'h07, 8'h3f} |-> lane_octets == `OCTETS_2)
      else $error("twelve-bit frame not two octets");
   refusal_hold_a: assert property (!sample_ready ##0 frame_held |=> !sample_ready)
      else $error("full buffer accepted more");
endmodule : lane_packer_properties

bind serial_lane_sample_packer lane_packer_properties #(.LANES(LANES)) i_props (
   .core_clk(core_clk), .rst_n(rst_n), .sample_valid(sample_valid),
   .sample_ready(sample_ready), .lane_valid(lane_valid), .lane_ready(lane_ready),
   .lane_a_data(lane_a_data), .lane_b_data(lane_b_data), .lane_a_enable(lane_a_enable),
   .lane_b_enable(lane_b_enable), .lane_octets(lane_octets), .format_error(format_error));

// ---- testbench/lane_receiver.sv ----
/*
 Receiver model: takes lane frames promptly, with random stalls, or not at all.
 Assumes the bench unpacks what it takes.
*/
`timescale 1ns/1ps
module lane_receiver (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] rx_mode,
   output logic lane_ready
);
   initial lane_ready = 1'b0;

   // Ready moves just after the edge: 0 prompt, 1 random stall, 2 halted
   always @(posedge core_clk)
      lane_ready <= #1 rst_n && (rx_mode == 2'd0 || (rx_mode == 2'd1 && $urandom % 3 != 0));
endmodule : lane_receiver

// ---- testbench/tb_serial_lane_sample_packer.sv ----
/*
 Self-checking bench of the serial lane sample packer.
 Assumes the design, its package and the receiver model are compiled before it.
*/
`timescale 1ns/1ps
`include "lane_packer_params.svh"
module tb_serial_lane_sample_packer
   import lane_packer_pkg::*;
   ;
   localparam time PERIOD = 40ns; // 25 MHz
   localparam logic [6:0] CODES [28] = '{7'h13, 7'h2a, 7'h14, 7'h2b, 7'h15, 7'h24, 7'h16,
      7'h2e, 7'h17, 7'h26, 7'h3d, 7'h40, 7'h45, 7'h47, 7'h18, 7'h30, 7'h3e, 7'h41, 7'h46,
      7'h19, 7'h34, 7'h1a, 7'h36, 7'h3f, 7'h1b, 7'h20, 7'h21, 7'h22};
   typedef struct {logic [127:0] a, b; logic [7:0] en; logic [1:0] oc; logic er;} frame_exp_t;
   logic core_clk, rst_n, sample_valid, sample_ready, lane_valid, lane_ready, format_error;
   logic [6:0] link_format_selector;
   logic [255:0] sample_data;
   logic [7:0] inphase_overrange_flag, quadrature_overrange_flag, lane_a_enable, lane_b_enable;
   logic [127:0] lane_a_data, lane_b_data;
   logic [1:0] lane_octets, rx_mode;
   int miscompares = 0;
   int total_checks = 0;
   frame_exp_t exp_q[$];

   serial_lane_sample_packer i_dut (.core_clk(core_clk), .rst_n(rst_n),
      .link_format_selector(link_format_selector), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_data(sample_data),
      .inphase_overrange_flag(inphase_overrange_flag),
      .quadrature_overrange_flag(quadrature_overrange_flag), .lane_valid(lane_valid),
      .lane_ready(lane_ready), .lane_a_data(lane_a_data), .lane_b_data(lane_b_data),
      .lane_a_enable(lane_a_enable), .lane_b_enable(lane_b_enable),
      .lane_octets(lane_octets), .format_error(format_error));
   lane_receiver i_rx (.core_clk(core_clk), .rst_n(rst_n), .rx_mode(rx_mode),
      .lane_ready(lane_ready));

   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #(PERIOD / 2) core_clk = ~core_clk;
   end

   // Expected lane frame: k is layout, n lanes per group
   function automatic frame_exp_t expect_frame(logic [6:0] c, logic [255:0] d, logic [7:0] fi,
      logic [7:0] fq);
      frame_exp_t e;
      logic [95:0] sa, sb;
      int k, n;
      k = 0;
      n = 0;
      case (c)
         7'h13, 7'h2a: begin k = 1; n = 6; end
         7'h20: begin k = 1; n = 3; end
         7'h14, 7'h2b: begin k = 2; n = 6; end
         7'h21: begin k = 2; n = 3; end
         7'h22: begin k = 3; n = 2; end
         7'h17, 7'h26, 7'h3d, 7'h40, 7'h45, 7'h47: begin k = 4; n = 1; end
         7'h15, 7'h24, 7'h18, 7'h30, 7'h3e, 7'h41, 7'h46: begin k = 4; n = 2; end
         7'h16, 7'h2e, 7'h1a, 7'h36, 7'h3f: begin k = 4; n = 4; end
         7'h1b: begin k = 4; n = 8; end
         7'h19, 7'h34: begin k = 5; n = 8; end
         default: k = 0;
      endcase
      e.a = '0;
      e.b = '0;
      e.er = (k == 0);
      e.en = 8'((1 << n) - 1);
      e.oc = (k == 3) ? `OCTETS_1 : `OCTETS_2;
      for (int i = 0; i < 8; i++)
      begin
         sa = {sa[83:0], (k == 1) ? d[32*i +: 12] : d[16*i +: 12]};
         sb = {sb[83:0], (k == 1) ? d[32*i+16 +: 12] : d[16*i+128 +: 12]};
      end
      for (int j = 0; j < n; j++)
      begin
         if (k < 3)
         begin
            e.a[16*j +: 16] = sa[95-16*j -: 16];
            e.b[16*j +: 16] = sb[95-16*j -: 16];
         end
         else if (k == 3)
         begin
            e.a[16*j +: 16] = {d[32*j +: 8], 8'h00};
            e.b[16*j +: 16] = {d[32*j+16 +: 8], 8'h00};
         end
         else
         begin
            e.a[16*j +: 16] = {d[16*j +: 15], fi[(k == 5) ? j / 2 : j]};
            e.b[16*j +: 16] = {d[16*j+128 +: 15], fq[(k == 5) ? j / 2 : j]};
         end
      end
      return e;
   endfunction : expect_frame

   task automatic check_frame(frame_exp_t e);
      total_checks++;
      if (lane_a_data !== e.a || lane_b_data !== e.b || lane_a_enable !== e.en
         || lane_b_enable !== e.en || format_error !== e.er || (!e.er && lane_octets !== e.oc))
      begin
         miscompares++;
         $display("unexpected at %0t: lane frame differs", $time);
      end
   endtask : check_frame

   task automatic check_bit(logic got, logic want, string what);
      total_checks++;
      if (got !== want)
      begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check_bit

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // Offer one frame, hold it until taken; valid stays high for back to back
   task automatic send(logic [6:0] c, bit corner);
      logic [255:0] d;
      logic [7:0] fi, fq;
      bit r;
      for (int i = 0; i < 8; i++)
         d[32*i +: 32] = corner ? 32'hffffffff : $urandom;
      fi = corner ? 8'haa : 8'($urandom);
      fq = corner ? 8'h55 : 8'($urandom);
      link_format_selector = c;
      sample_data = d;
      inphase_overrange_flag = fi;
      quadrature_overrange_flag = fq;
      sample_valid = 1'b1;
      r = 1'b0;
      while (!r)
      begin
         @(negedge core_clk);
         r = (sample_ready === 1'b1);
         @(posedge core_clk);
      end
      exp_q.push_back(expect_frame(c, d, fi, fq));
      #1;
   endtask : send

   task automatic idle_drain;
      sample_valid = 1'b0;
      for (int i = 0; i < 300 && (exp_q.size() != 0 || lane_valid === 1'b1); i++)
         @(posedge core_clk);
      #1;
      check_bit(exp_q.size() == 0, 1'b1, "frames missing");
   endtask : idle_drain

   // Every frame the receiver takes is unpacked against the expectation
   always @(negedge core_clk)
      if (lane_valid === 1'b1 && lane_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check_bit(1'b1, 1'b0, "extra lane frame");
         else
            check_frame(exp_q.pop_front());
      end

   initial
   begin
      #(PERIOD * 20000);
      check_bit(1'b1, 1'b0, "run timed out");
      report_and_stop();
   end

   initial
   begin
      rst_n = 1'b0;
      sample_valid = 1'b0;
      link_format_selector = 7'h00;
      sample_data = '0;
      inphase_overrange_flag = 8'h00;
      quadrature_overrange_flag = 8'h00;
      rx_mode = 2'd0;
      void'($urandom(36));
      repeat (12) @(posedge core_clk);
      #1;
      check_bit(lane_valid, 1'b0, "valid in reset");
      check_bit(lane_octets === `OCTETS_RST && lane_a_enable === 8'h00, 1'b1, "reset outputs");
      rst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      rx_mode = 2'd1;
      foreach (CODES[i])
         for (int f = 0; f < 3; f++)
         begin
            send(CODES[i], f == 0);
            if ($urandom % 2)
            begin
               sample_valid = 1'b0;
               @(posedge core_clk);
               #1;
            end
         end
      idle_drain();
      $display("test of all formats ended");
      send(7'h00, 1'b0);
      send(7'h7f, 1'b1);
      idle_drain();
      $display("test of unsupported selectors ended");
      rx_mode = 2'd2;
      fork
         for (int f = 0; f < 20; f++)
            send(CODES[f], 1'b0);
      join_none
      for (int i = 0; i < 60 && sample_ready !== 1'b0; i++)
         @(negedge core_clk);
      check_bit(sample_ready, 1'b0, "full buffer not refusing");
      rx_mode = 2'd1;
      wait fork;
      idle_drain();
      $display("test of buffer fill ended");
      report_and_stop();
   end
endmodule : tb_serial_lane_sample_packer
